// ---- hw/sleep_entry_top.sv ----
// Sleep-entry handshake of a two-wire memory target: pin driver and power state
`timescale 1ns/1ps
`default_nettype none
module sleep_entry_top #(
    parameter logic [6:0]  TARGET_ADDR = sleep_link_pkg::TARGET_ADDR_RV,
    parameter int unsigned REC_CYCLES  = sleep_link_pkg::REC_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n_o,
    output logic      sleep_o,
    output logic      ready_o
);
    import sleep_link_pkg::*;

    localparam int unsigned CW = (REC_CYCLES > 1) ? $clog2(REC_CYCLES) : 1;
    localparam logic [CW-1:0] REC_LAST = CW'(REC_CYCLES - 1);

    typedef struct packed {
        logic          scl_m;
        logic          scl_s;
        logic          scl_d;
        logic          sda_m;
        logic          sda_s;
        logic          sda_d;
        logic          ack_m;
        logic          ack_s;
        logic          kind_m;
        logic          kind_s;
        power_e        st;
        logic          kind;
        logic          done;
        logic          oe_n;
        logic          sda_out;
        logic [CW-1:0] cnt;
        logic          sleep;
        logic          awake;
    } top_s;

    top_s r;
    top_s n;
    logic ack_req;
    logic sleep_kind;
    logic scl_rise;
    logic scl_fall;
    logic start_det;

    // Receiver lives on the serial clock; it only hands over two slow levels
    sleep_link_rx #(
        .TARGET_ADDR (TARGET_ADDR)
    ) u_rx (
        .scl_i        (scl_i),
        .sda_i        (sda_i),
        .srst_i       (srst_i),
        .ack_req_o    (ack_req),
        .sleep_kind_o (sleep_kind)
    );

    // Edge detectors read only the second stage and its delayed copy
    assign scl_rise  = r.scl_s & ~r.scl_d;
    assign scl_fall  = ~r.scl_s & r.scl_d;
    assign start_det = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;

    always_comb begin
        n        = r;
        n.scl_m  = scl_i;
        n.scl_s  = r.scl_m;
        n.scl_d  = r.scl_s;
        n.sda_m  = sda_i;
        n.sda_s  = r.sda_m;
        n.sda_d  = r.sda_s;
        n.ack_m  = ack_req;
        n.ack_s  = r.ack_m;
        n.kind_m = sleep_kind;
        n.kind_s = r.kind_m;
        if (!r.ack_s) begin
            n.done = 1'b0;
        end
        unique case (r.st)
            PW_AWAKE: begin
                if (r.ack_s && !r.done) begin
                    n.oe_n = 1'b0;
                    n.st   = PW_ACK_LO;
                end
            end
            PW_ACK_LO: begin
                // Kind is sampled a few cycles after the request, so it has settled
                n.kind = r.kind_s;
                if (!r.ack_s) begin
                    n.oe_n = 1'b1;
                    n.st   = PW_AWAKE;
                end else if (scl_rise) begin
                    if (r.kind) begin
                        // No STOP awaited; release may itself look like one
                        n.oe_n  = 1'b1;
                        n.done  = 1'b1;
                        n.st    = PW_SLEEP;
                        n.sleep = 1'b1;
                        n.awake = 1'b0;
                    end else begin
                        n.st = PW_ACK_HI;
                    end
                end
            end
            PW_ACK_HI: begin
                // Ordinary acknowledge is held through the high phase
                if (scl_fall || !r.ack_s) begin
                    n.oe_n = 1'b1;
                    n.done = 1'b1;
                    n.st   = PW_AWAKE;
                end
            end
            PW_SLEEP: begin
                // Spurious STOP from the release is simply not looked at
                n.oe_n = 1'b1;
                if (r.ack_s) begin
                    n.done = 1'b1;
                end
                if (start_det) begin
                    n.st  = PW_RECOVER;
                    n.cnt = '0;
                end
            end
            PW_RECOVER: begin
                // Requests raised while waking are dropped, not acknowledged late
                n.oe_n = 1'b1;
                if (r.ack_s) begin
                    n.done = 1'b1;
                end
                n.cnt = r.cnt + CW'(1);
                if (r.cnt == REC_LAST) begin
                    n.st    = PW_AWAKE;
                    n.sleep = 1'b0;
                    n.awake = 1'b1;
                end
            end
            default: begin
                n.oe_n = 1'b1;
                n.st   = PW_AWAKE;
            end
        endcase
        if (srst_i) begin
            n.st      = PW_AWAKE;
            n.kind    = 1'b0;
            n.done    = 1'b0;
            n.oe_n    = 1'b1;
            n.sda_out = 1'b0;
            n.cnt     = '0;
            n.sleep   = 1'b0;
            n.awake   = 1'b1;
            n.ack_m   = 1'b0;
            n.ack_s   = 1'b0;
            n.kind_m  = 1'b0;
            n.kind_s  = 1'b0;
            n.scl_m   = 1'b1;
            n.scl_s   = 1'b1;
            n.scl_d   = 1'b1;
            n.sda_m   = 1'b1;
            n.sda_s   = 1'b1;
            n.sda_d   = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        r <= n;
    end

    // Open-drain: the data bit is always low, only the enable moves
    assign sda_o      = r.sda_out;
    assign sda_oe_n_o = r.oe_n;
    assign sleep_o    = r.sleep;
    assign ready_o    = r.awake;

    property p_ack_drives;
        @(posedge clk_i) disable iff (srst_i)
        (r.st == PW_AWAKE && r.ack_s && !r.done) |=> !sda_oe_n_o && r.st == PW_ACK_LO;
    endproperty
    a_ack_drives: assert property (p_ack_drives)
        else $error("acknowledge not driven low");

    property p_release_at_rise;
        @(posedge clk_i) disable iff (srst_i)
        (r.st == PW_ACK_LO && r.ack_s && r.kind && scl_rise) |=> sda_oe_n_o && sleep_o;
    endproperty
    a_release_at_rise: assert property (p_release_at_rise)
        else $error("sleep acknowledge not released at ninth rising edge");

    property p_asleep_released;
        @(posedge clk_i) disable iff (srst_i)
        (r.st == PW_SLEEP) |-> sda_oe_n_o && sleep_o && !ready_o;
    endproperty
    a_asleep_released: assert property (p_asleep_released)
        else $error("line driven or ready while asleep");

    property p_sleep_on_clock;
        @(posedge clk_i) disable iff (srst_i)
        $rose(sleep_o) |-> $past(scl_rise) && $past(r.st) == PW_ACK_LO;
    endproperty
    a_sleep_on_clock: assert property (p_sleep_on_clock)
        else $error("sleep entered other than at the clock edge");

    property p_float_after;
        @(posedge clk_i) disable iff (srst_i)
        (r.st == PW_ACK_LO && r.ack_s && r.kind && scl_rise) |=> sda_oe_n_o [*4];
    endproperty
    a_float_after: assert property (p_float_after)
        else $error("line pulled again after sleep release");

    property p_normal_ack_held;
        @(posedge clk_i) disable iff (srst_i)
        (r.st == PW_ACK_HI && !scl_fall && r.ack_s) |=> !sda_oe_n_o;
    endproperty
    a_normal_ack_held: assert property (p_normal_ack_held)
        else $error("address acknowledge dropped during high phase");

    property p_wake_only_after_recovery;
        @(posedge clk_i) disable iff (srst_i)
        $rose(ready_o) |-> $past(r.st) == PW_RECOVER && $past(r.cnt) == REC_LAST;
    endproperty
    a_wake_only_after_recovery: assert property (p_wake_only_after_recovery)
        else $error("ready raised before recovery count finished");

endmodule
`default_nettype wire

// ---- hw/sleep_link_pkg.sv ----
// Constants, state encodings and timing counts for the sleep-entry block
// Behaviour
// - The device acknowledges the sleep identifier 86h that closes the sleep sequence by pulling SDA low in the ninth clock.
// - After that acknowledge the device stops driving SDA as soon as the ninth SCL rising edge has occurred.
// - Sleep entry starts at that ninth SCL rising edge and SDA stays released while asleep.
// - The device goes to sleep after the acknowledged identifier without waiting for a STOP.
// - Releasing SDA while SCL is high makes a STOP on the bus that the controller never sent.
`default_nettype none
package sleep_link_pkg;

    // Sleep sequence: START, reserved ID, own address + write, repeated START, sleep ID
    localparam logic [7:0] RSVD_ID        = 8'hF8;
    localparam logic [7:0] SLEEP_ID       = 8'h86;
    localparam logic [6:0] TARGET_ADDR_RV = 7'h50;
    localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
    localparam logic [3:0] ACK_SLOT       = 4'h8;

    localparam int unsigned CLK_FREQ_MHZ  = 200;
    localparam int unsigned REC_TIME_US   = 400;
    localparam int unsigned REC_CYCLES    = REC_TIME_US * CLK_FREQ_MHZ;

    typedef enum logic [4:0] {
        LK_IDLE    = 5'b0_0001,
        LK_RSVD    = 5'b0_0010,
        LK_ADDR    = 5'b0_0100,
        LK_WAIT_RS = 5'b0_1000,
        LK_CMD     = 5'b1_0000
    } link_e;

    typedef enum logic [4:0] {
        PW_AWAKE   = 5'b0_0001,
        PW_ACK_LO  = 5'b0_0010,
        PW_ACK_HI  = 5'b0_0100,
        PW_SLEEP   = 5'b0_1000,
        PW_RECOVER = 5'b1_0000
    } power_e;

endpackage
`default_nettype wire

// ---- hw/sleep_link_rx.sv ----
// Serial-clock domain receiver that recognises the sleep command sequence
`timescale 1ns/1ps
`default_nettype none
module sleep_link_rx #(
    parameter logic [6:0] TARGET_ADDR = sleep_link_pkg::TARGET_ADDR_RV
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic srst_i,
    output logic      ack_req_o,
    output logic      sleep_kind_o
);
    import sleep_link_pkg::*;

    typedef struct packed {
        logic       rst_m;
        logic       rst_s;
        link_e      st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic       ack;
        logic       kind;
    } rx_s;

    rx_s  r;
    rx_s  n;
    logic pos_sda_r;
    logic [7:0] byte_w;
    logic start_w;
    logic stop_w;

    // Bit value is taken at the rising edge; frame edges show as a change by the falling edge
    always_ff @(posedge scl_i) begin
        pos_sda_r <= sda_i;
    end

    assign byte_w  = {r.sh[6:0], pos_sda_r};
    assign start_w = pos_sda_r & ~sda_i;
    assign stop_w  = ~pos_sda_r & sda_i;

    always_comb begin
        n       = r;
        n.rst_m = srst_i;
        n.rst_s = r.rst_m;
        if (r.rst_s) begin
            n.st   = LK_IDLE;
            n.cnt  = 4'h0;
            n.ack  = 1'b0;
            n.kind = 1'b0;
        end else if (start_w) begin
            // Repeated START only continues the sequence right after the address
            n.st   = (r.st == LK_WAIT_RS) ? LK_CMD : LK_RSVD;
            n.cnt  = 4'h0;
            n.ack  = 1'b0;
            n.kind = 1'b0;
        end else if (stop_w) begin
            n.st   = LK_IDLE;
            n.cnt  = 4'h0;
            n.ack  = 1'b0;
            n.kind = 1'b0;
        end else if (r.st != LK_IDLE) begin
            if (r.cnt == ACK_SLOT) begin
                n.cnt  = 4'h0;
                n.ack  = 1'b0;
                n.kind = 1'b0;
                if (r.st == LK_CMD) begin
                    n.st = LK_IDLE;
                end
            end else begin
                n.sh  = byte_w;
                n.cnt = r.cnt + 4'h1;
                if (r.cnt == LAST_DATA_BIT) begin
                    unique case (r.st)
                        LK_RSVD: begin
                            n.st = (byte_w == RSVD_ID) ? LK_ADDR : LK_IDLE;
                        end
                        LK_ADDR: begin
                            if (byte_w == {TARGET_ADDR, 1'b0}) begin
                                n.ack = 1'b1;
                                n.st  = LK_WAIT_RS;
                            end else begin
                                n.st = LK_IDLE;
                            end
                        end
                        LK_WAIT_RS: begin
                            n.st = LK_IDLE;
                        end
                        LK_CMD: begin
                            // Sleep only at the end of a whole sequence
                            if (byte_w == SLEEP_ID) begin
                                n.ack  = 1'b1;
                                n.kind = 1'b1;
                            end else begin
                                n.st = LK_IDLE;
                            end
                        end
                        default: begin
                            n.st = LK_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(negedge scl_i) begin
        r <= n;
    end

    assign ack_req_o    = r.ack;
    assign sleep_kind_o = r.kind;

    property p_sleep_from_cmd;
        @(negedge scl_i) disable iff (r.rst_s)
        $rose(r.kind) |-> $past(r.st) == LK_CMD && $past(r.cnt) == LAST_DATA_BIT;
    endproperty
    a_sleep_from_cmd: assert property (p_sleep_from_cmd)
        else $error("sleep request outside a complete sleep sequence");

    property p_ack_one_slot;
        @(negedge scl_i) disable iff (r.rst_s)
        (r.ack && !start_w && !stop_w) |=> !r.ack;
    endproperty
    a_ack_one_slot: assert property (p_ack_one_slot)
        else $error("acknowledge request held past its slot");

endmodule
`default_nettype wire

// ---- tb/sleep_ctrl_model.sv ----
// Two-wire bus controller model that issues the sleep command sequence
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl_model (
    output logic      scl_o,
    output logic      sda_pull_o,
    input  wire logic sda_i
);
    localparam time Q = 12ns;

    // Clock stands high between frames, data released to the pull-up
    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end

    // Short idle pulses only used while reset syncs the receiver
    task automatic scl_pulse();
        #Q scl_o = 1'b0;
        #Q scl_o = 1'b1;
    endtask

    task automatic bus_start();
        #Q sda_pull_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b1;
        #Q scl_o = 1'b0;
    endtask

    // Receiver recognises a condition at the next fall, hence one idle pulse
    task automatic bus_stop();
        #Q sda_pull_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b0;
        #Q scl_o = 1'b0;
        #Q scl_o = 1'b1;
        #(2*Q);
    endtask

    // A spurious STOP after the sleep ID is not tracked; transfer state carries on
    task automatic put_byte(input logic [7:0] b, input bit hold, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #Q sda_pull_o = ~b[i];
            #Q scl_o = 1'b1;
            #(2*Q) scl_o = 1'b0;
        end
        #Q sda_pull_o = 1'b0;
        #Q scl_o = 1'b1;
        ack = ~sda_i;
        if (hold && ack) sda_pull_o = 1'b1;
        #(2*Q) scl_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/sleep_entry_top_tb.sv ----
// Self-checking bench for the sleep-entry handshake against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module sleep_entry_top_tb;
    import sleep_link_pkg::*;
    localparam logic [6:0]  ADDR = 7'h2B;
    localparam int unsigned REC  = 200;
    logic      clk_i;
    logic      srst_i;
    logic      scl;
    logic      pull;
    wire logic sda;
    logic      sda_o;
    logic      sda_oe_n_o;
    logic      sleep_o;
    logic      ready_o;
    int        failures;
    int        n_compared;
    int        stops;
    int        exp_stops;
    int        st;
    int        cyc;
    bit        asleep;

    // Open drain with pull-up
    assign sda = (pull || !sda_oe_n_o) ? 1'b0 : 1'b1;

    sleep_entry_top #(
        .TARGET_ADDR (ADDR),
        .REC_CYCLES  (REC)
    ) u_sleep_entry_top (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .scl_i      (scl),
        .sda_i      (sda),
        .sda_o      (sda_o),
        .sda_oe_n_o (sda_oe_n_o),
        .sleep_o    (sleep_o),
        .ready_o    (ready_o)
    );

    sleep_ctrl_model u_sleep_ctrl_model (
        .scl_o      (scl),
        .sda_pull_o (pull),
        .sda_i      (sda)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) cyc <= cyc + 1;
    always @(posedge sda) if (scl === 1'b1) stops++;

    task automatic chk(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic start();
        u_sleep_ctrl_model.bus_start();
        st = (st == 2) ? 3 : 0;
    endtask

    task automatic stop();
        u_sleep_ctrl_model.bus_stop();
        exp_stops++;
        st = -1;
    endtask

    // Reference sequence tracker decides every acknowledge
    task automatic xfer(input logic [7:0] b, input bit hold);
        logic ack;
        logic exp;
        bit   slp;
        exp = 1'b0;
        slp = 1'b0;
        if (!asleep) begin
            case (st)
                0: st = (b == RSVD_ID) ? 1 : -1;
                1: begin
                    exp = (b == {ADDR, 1'b0});
                    st = exp ? 2 : -1;
                end
                3: begin
                    exp = (b == SLEEP_ID);
                    slp = exp;
                    st = -1;
                end
                default: st = -1;
            endcase
        end
        u_sleep_ctrl_model.put_byte(b, hold, ack);
        chk(ack, exp, "acknowledge");
        if (slp) begin
            asleep = 1'b1;
            if (!hold) exp_stops++;
        end
    endtask

    // Mutation 0 is the proper sequence, 1..5 each break one step
    task automatic sleep_seq(input int mut, input bit hold);
        logic [7:0] r;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        r  = 8'($urandom) | 8'h01;
        b0 = (mut == 1) ? RSVD_ID ^ r : RSVD_ID;
        b1 = (mut == 2) ? {ADDR ^ r[6:0], 1'b0} : {ADDR, 1'b0};
        b2 = (mut == 3) ? SLEEP_ID ^ r : SLEEP_ID;
        start();
        xfer(b0, 1'b0);
        xfer(b1, 1'b0);
        if (mut == 4) xfer(r, 1'b0);
        if (mut == 5) stop();
        start();
        xfer(b2, hold);
        repeat (6) @(posedge clk_i);
        chk(sleep_o, asleep, "sleep flag");
        chk(ready_o, !asleep, "ready flag");
        chk(sda_oe_n_o, 1'b1, "data line released");
        chk(stops == exp_stops, 1'b1, "stop count on the bus");
    endtask

    // Any START wakes; the waking access itself gets no acknowledge
    task automatic wake();
        int c0;
        start();
        c0 = cyc;
        xfer({ADDR, 1'b0}, 1'b0);
        while (ready_o !== 1'b1 && cyc - c0 < REC + 50) @(posedge clk_i);
        chk(cyc - c0 >= REC - 4 && cyc - c0 <= REC + 8, 1'b1, "recovery time");
        chk(sleep_o, 1'b0, "sleep flag after recovery");
        asleep = 1'b0;
        stop();
    endtask

    initial begin
        srst_i = 1'b1;
        st = -1;
        void'($urandom(8));
        fork
            begin
                u_sleep_ctrl_model.scl_pulse();
                u_sleep_ctrl_model.scl_pulse();
            end
            begin
                repeat (10) @(posedge clk_i);
                srst_i <= 1'b0;
            end
        join
        // Receiver leaves its reset only after two more serial clock falls
        u_sleep_ctrl_model.scl_pulse();
        u_sleep_ctrl_model.scl_pulse();
        @(posedge clk_i);
        #1;
        chk(sda_oe_n_o, 1'b1, "reset enable");
        chk(sda_o, 1'b0, "reset data");
        chk(sleep_o, 1'b0, "reset sleep");
        chk(ready_o, 1'b1, "reset ready");
        stops = 0;
        exp_stops = 0;
        sleep_seq(0, 1'b0);
        wake();
        sleep_seq(0, 1'b1);
        wake();
        for (int m = 1; m <= 5; m++) begin
            sleep_seq(m, 1'b0);
            stop();
        end
        sleep_seq(0, 1'b0);
        wake();
        summarize();
    end

    // About 16 us of traffic expected; some six times that is a hang
    initial begin
        #100us;
        failures++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        summarize();
    end
endmodule
`default_nettype wire
